// *** inc/alarm_mon_pkg.sv ***
// Constants for the drop/add bus alarm monitor.
// Assumes a 20 MHz system clock and a 32-bit classic Wishbone slave port.
`default_nettype none
package alarm_mon_pkg;
   // Timing
   localparam int CLK_NS = 50;
   localparam int LOC_NS = 1000;
   localparam int LOC_CYC = (LOC_NS + CLK_NS - 1) / CLK_NS;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_BUS_LAT = 6'h22;
   localparam logic [5:0] IDX_BUS_LIVE = 6'h23;
   localparam logic [5:0] IDX_EXT_LAT = 6'h24;
   localparam logic [5:0] IDX_EXT_LIVE = 6'h25;
   localparam logic [5:0] IDX_B_LAT = 6'h26;
   localparam logic [5:0] IDX_CTRL = 6'h30;
   localparam logic [5:0] IDX_IRQ_STAT = 6'h31;
   localparam logic [5:0] IDX_IRQ_CLR = 6'h32;
   localparam logic [5:0] IDX_IRQ_EN = 6'h33;
   // Control fields
   localparam int CTRL_ADD_TIMING = 0;
   localparam int CTRL_AIS_SEL = 1;
   localparam int CTRL_MF_SEL = 2;
   localparam int CTRL_PAR_ODD = 3;
   localparam int CTRL_FMT_LO = 4;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [1:0] FMT_AU3 = 2'h0;
   // Bus alarm fields
   localparam int BUS_DROP_LOC = 7;
   localparam int BUS_ADD_LOC = 6;
   localparam int BUS_PAR = 5;
   // External clock / multiframe fields
   localparam int EXT_LOC = 7;
   localparam logic [2:0] MF_LOSS_RST = 3'h7;
   localparam logic [7:0] LAT_RST = 8'h00;
   // Interrupt status bits
   localparam int IRQ_BUS = 0;
   localparam int IRQ_EXT = 1;
   localparam logic [7:0] ALL_ONES = 8'hFF;
endpackage
`default_nettype wire

// *** src/drop_add_bus_alarm_monitor.sv ***
// A-side drop/add bus alarm monitor with Wishbone status registers.
// Assumes all drop bus pins and clocks are asynchronous to clk_i.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Drop clock stuck 1000 ns raises alarm
// - Clock loss clears on first transition
// - Drop timing loss tristates add outputs
// - Add timing: add clock stuck raises alarm
// - Add clock loss tristates add outputs
// - Drop parity checked every drop clock
// - Parity error only sets status
// - Unused status bits read zero
// - Source 0: AIS from H1/H2 bytes
// - Source 1: AIS from E1x bytes
// - Tributaries two, three AIS off formats
// - External clock stuck raises alarm
// - Two bad multiframes declare multiframe loss
// - Expected H4 phase steps 00..11
// - Free running, relock after good sequence
// - H4 tribs two, three off formats
// - Multiframe loss bits one at reset
// - Latched register one address below live
module drop_add_bus_alarm_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq_o,
   input wire logic drop_clk_i,
   input wire logic add_clk_i,
   input wire logic desync_ref_clock_i,
   input wire logic [7:0] drop_data_i,
   input wire logic drop_parity_i,
   input wire logic drop_h1_i,
   input wire logic drop_h2_i,
   input wire logic drop_e1_i,
   input wire logic drop_h4_i,
   input wire logic [1:0] drop_trib_i,
   input wire logic [7:0] add_data_i,
   input wire logic add_parity_i,
   input wire logic add_indicator_i,
   output logic [7:0] add_data_o,
   output logic add_parity_o,
   output logic add_indicator_o,
   output logic add_oe_o
);
   localparam int NPIN = 18;
   localparam logic [4:0] LOC_LAST = 5'(alarm_mon_pkg::LOC_CYC - 1);

   function automatic logic is_ones(input logic [7:0] b);
      return b == alarm_mon_pkg::ALL_ONES;
   endfunction

   // Pin synchronisers; s1 feeds only s2
   logic [NPIN-1:0] s1, s2, s3;
   always_ff @(posedge clk_i) begin
      s1 <= {drop_clk_i, add_clk_i, desync_ref_clock_i, drop_data_i, drop_parity_i,
             drop_h1_i, drop_h2_i, drop_e1_i, drop_h4_i, drop_trib_i};
      s2 <= s1;
      s3 <= s2;
   end
   logic [2:0] ck, ckp, edge_seen;
   logic [7:0] dd;
   logic dpar, dh1, dh2, de1, dh4, drop_rise;
   logic [1:0] dtrib;
   assign ck = s2[17:15];
   assign ckp = s3[17:15];
   assign edge_seen = ck ^ ckp;
   assign {dd, dpar, dh1, dh2, de1, dh4, dtrib} = s2[14:0];
   assign drop_rise = ck[2] & ~ckp[2];

   // Control register
   logic [5:0] ctrl;
   logic add_timing, ais_sel, mf_sel, par_odd;
   logic [1:0] fmt;
   logic [2:0] trib_en;
   assign add_timing = ctrl[alarm_mon_pkg::CTRL_ADD_TIMING];
   assign ais_sel = ctrl[alarm_mon_pkg::CTRL_AIS_SEL];
   assign mf_sel = ctrl[alarm_mon_pkg::CTRL_MF_SEL];
   assign par_odd = ctrl[alarm_mon_pkg::CTRL_PAR_ODD];
   assign fmt = ctrl[alarm_mon_pkg::CTRL_FMT_LO +: 2];
   assign trib_en = {{2{fmt == alarm_mon_pkg::FMT_AU3}}, 1'b1};

   // Loss of clock: index 2 drop, 1 add, 0 external
   logic [4:0] loc_cnt [3];
   logic [4:0] next_loc_cnt [3];
   logic [2:0] lost, next_lost;
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         next_loc_cnt[k] = loc_cnt[k];
         next_lost[k] = lost[k];
         if (edge_seen[k]) begin
            next_loc_cnt[k] = 5'h00;
            next_lost[k] = 1'b0;
         end else if (loc_cnt[k] == LOC_LAST) begin
            next_lost[k] = 1'b1;
         end else begin
            next_loc_cnt[k] = loc_cnt[k] + 5'h01;
         end
      end
      // add clock watched only in add timing
      if (!add_timing) begin
         next_lost[1] = 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < 3; k++) begin
            loc_cnt[k] <= 5'h00;
         end
         lost <= 3'h0;
      end else begin
         loc_cnt <= next_loc_cnt;
         lost <= next_lost;
      end
   end

   // Add bus outputs; data path untouched by parity
   logic kill;
   // add outputs off during loss of the selected timing clock (add in add timing, else drop)
   assign kill = add_timing ? lost[1] : lost[2];
   logic [7:0] next_add_data;
   logic next_add_par, next_add_ind, next_add_oe;
   always_comb begin
      next_add_data = add_data_i;
      next_add_par = add_parity_i;
      next_add_ind = add_indicator_i & ~kill;
      next_add_oe = ~kill;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         add_data_o <= 8'h00;
         add_parity_o <= 1'b0;
         add_indicator_o <= 1'b0;
         add_oe_o <= 1'b0;
      end else begin
         add_data_o <= next_add_data;
         add_parity_o <= next_add_par;
         add_indicator_o <= next_add_ind;
         add_oe_o <= next_add_oe;
      end
   end

   // Parity, AIS and H4 monitors on drop clock rising edges
   logic par_err, next_par_err;
   logic [2:0] h1_ff, next_h1_ff, ais_ptr, next_ais_ptr, ais_e1, next_ais_e1;
   logic [1:0] mf_ctr [3];
   logic [1:0] next_mf_ctr [3];
   logic [1:0] good [3];
   logic [1:0] next_good [3];
   logic [2:0] miss, next_miss, bad_mf, next_bad_mf, lof, next_lof;
   logic [1:0] exp_h4;
   always_comb begin
      next_par_err = par_err;
      next_h1_ff = h1_ff;
      next_ais_ptr = ais_ptr;
      next_ais_e1 = ais_e1;
      next_mf_ctr = mf_ctr;
      next_good = good;
      next_miss = miss;
      next_bad_mf = bad_mf;
      next_lof = lof;
      exp_h4 = 2'h0;
      if (drop_rise) begin
         next_par_err = (^{dd, dpar}) != par_odd;
         for (int t = 0; t < 3; t++) begin
            if (dtrib == 2'(t)) begin
               if (dh1) next_h1_ff[t] = is_ones(dd);
               if (dh2) next_ais_ptr[t] = h1_ff[t] & is_ones(dd);
               if (de1) next_ais_e1[t] = is_ones(dd);
               if (dh4 && !mf_sel && trib_en[t]) begin
                  exp_h4 = mf_ctr[t] + 2'h1;
                  if (lof[t]) begin
                     // follow received phase, relock on four good
                     next_mf_ctr[t] = dd[1:0];
                     next_good[t] = (dd[1:0] == exp_h4) ? good[t] + 2'h1 : 2'h0;
                     if (dd[1:0] == exp_h4 && good[t] == 2'h3) begin
                        next_lof[t] = 1'b0;
                        next_bad_mf[t] = 1'b0;
                        next_miss[t] = 1'b0;
                     end
                  end else begin
                     next_mf_ctr[t] = exp_h4;
                     next_miss[t] = miss[t] | (dd[1:0] != exp_h4);
                     if (exp_h4 == 2'h3) begin
                        next_miss[t] = 1'b0;
                        // second bad multiframe in a row
                        if (miss[t] || dd[1:0] != exp_h4) begin
                           next_bad_mf[t] = 1'b1;
                           next_lof[t] = bad_mf[t];
                           next_good[t] = 2'h0;
                        end else begin
                           next_bad_mf[t] = 1'b0;
                        end
                     end
                  end
               end
            end
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         par_err <= 1'b0;
         h1_ff <= 3'h0;
         ais_ptr <= 3'h0;
         ais_e1 <= 3'h0;
         for (int t = 0; t < 3; t++) begin
            mf_ctr[t] <= 2'h0;
            good[t] <= 2'h0;
         end
         miss <= 3'h0;
         bad_mf <= 3'h0;
         lof <= alarm_mon_pkg::MF_LOSS_RST;
      end else begin
         par_err <= next_par_err;
         h1_ff <= next_h1_ff;
         ais_ptr <= next_ais_ptr;
         ais_e1 <= next_ais_e1;
         mf_ctr <= next_mf_ctr;
         good <= next_good;
         miss <= next_miss;
         bad_mf <= next_bad_mf;
         lof <= next_lof;
      end
   end

   // Live status images
   logic [7:0] bus_live, ext_live;
   assign bus_live = {lost[2], lost[1], par_err, 2'b00,
                      (ais_sel ? ais_e1 : ais_ptr) & trib_en};
   assign ext_live = {lost[0], 4'h0, lof & trib_en};

   // Wishbone slave, latched and interrupt registers
   logic [7:0] bus_lat, next_bus_lat, ext_lat, next_ext_lat, bus_prev, ext_prev;
   logic [1:0] irq_stat, next_irq_stat, irq_en, next_irq_en;
   logic [5:0] next_ctrl;
   logic [31:0] next_dat;
   logic next_ack, wr;
   logic [5:0] idx;
   assign idx = adr_i[7:2];
   always_comb begin
      next_ack = cyc_i & stb_i & ~ack_o;
      wr = next_ack & we_i & sel_i[0];
      next_ctrl = ctrl;
      next_irq_en = irq_en;
      next_dat = 32'h0000_0000;
      // write one clears, a new event wins
      next_bus_lat = bus_lat;
      next_ext_lat = ext_lat;
      next_irq_stat = irq_stat;
      if (wr) begin
         unique case (idx)
            alarm_mon_pkg::IDX_BUS_LAT: next_bus_lat = bus_lat & ~dat_i[7:0];
            alarm_mon_pkg::IDX_EXT_LAT: next_ext_lat = ext_lat & ~dat_i[7:0];
            alarm_mon_pkg::IDX_CTRL: next_ctrl = dat_i[5:0];
            alarm_mon_pkg::IDX_IRQ_CLR: next_irq_stat = irq_stat & ~dat_i[1:0];
            alarm_mon_pkg::IDX_IRQ_EN: next_irq_en = dat_i[1:0];
            default: next_ctrl = ctrl;
         endcase
      end
      next_bus_lat = next_bus_lat | bus_live;
      next_ext_lat = next_ext_lat | ext_live;
      next_irq_stat[alarm_mon_pkg::IRQ_BUS] = next_irq_stat[alarm_mon_pkg::IRQ_BUS]
         | (|(bus_live & ~bus_prev));
      next_irq_stat[alarm_mon_pkg::IRQ_EXT] = next_irq_stat[alarm_mon_pkg::IRQ_EXT]
         | (|(ext_live & ~ext_prev));
      if (next_ack && !we_i) begin
         // latched copy one index below live
         unique case (idx)
            alarm_mon_pkg::IDX_BUS_LAT: next_dat[7:0] = bus_lat;
            alarm_mon_pkg::IDX_BUS_LIVE: next_dat[7:0] = bus_live;
            alarm_mon_pkg::IDX_EXT_LAT: next_dat[7:0] = ext_lat;
            alarm_mon_pkg::IDX_EXT_LIVE: next_dat[7:0] = ext_live;
            alarm_mon_pkg::IDX_CTRL: next_dat[5:0] = ctrl;
            alarm_mon_pkg::IDX_IRQ_STAT: next_dat[1:0] = irq_stat;
            alarm_mon_pkg::IDX_IRQ_EN: next_dat[1:0] = irq_en;
            default: next_dat = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
         ctrl <= alarm_mon_pkg::CTRL_RST;
         bus_lat <= alarm_mon_pkg::LAT_RST;
         ext_lat <= alarm_mon_pkg::LAT_RST;
         bus_prev <= 8'h00;
         ext_prev <= 8'h00;
         irq_stat <= 2'h0;
         irq_en <= 2'h0;
         irq_o <= 1'b0;
      end else begin
         ack_o <= next_ack;
         dat_o <= next_dat;
         ctrl <= next_ctrl;
         bus_lat <= next_bus_lat;
         ext_lat <= next_ext_lat;
         bus_prev <= bus_live;
         ext_prev <= ext_live;
         irq_stat <= next_irq_stat;
         irq_en <= next_irq_en;
         irq_o <= |(next_irq_stat & next_irq_en);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_drop_loc_set;
      !edge_seen[2] && loc_cnt[2] == LOC_LAST |=> lost[2];
   endproperty
   a_drop_loc_set: assert property (p_drop_loc_set) else $error("drop clock loss not raised");

   property p_loc_clear;
      edge_seen[2] |=> !lost[2] && loc_cnt[2] == 5'h00;
   endproperty
   a_loc_clear: assert property (p_loc_clear) else $error("drop clock loss not cleared");

   sequence s_drop_kill;
      !add_timing && lost[2];
   endsequence
   property p_drop_kill;
      s_drop_kill |=> !add_oe_o && !add_indicator_o;
   endproperty
   a_drop_kill: assert property (p_drop_kill) else $error("add bus driven in drop loss");

   property p_add_kill;
      add_timing && lost[1] |=> !add_oe_o && !add_indicator_o;
   endproperty
   a_add_kill: assert property (p_add_kill) else $error("add bus driven in add loss");

   property p_add_loc_mode;
      !add_timing |=> !lost[1];
   endproperty
   a_add_loc_mode: assert property (p_add_loc_mode) else $error("add loss outside add mode");

   property p_ext_loc;
      !edge_seen[0] && loc_cnt[0] == LOC_LAST |=> lost[0];
   endproperty
   a_ext_loc: assert property (p_ext_loc) else $error("external clock loss not raised");

   property p_parity;
      drop_rise |=> par_err == ((^$past(dd) ^ $past(dpar)) != $past(par_odd));
   endproperty
   a_parity: assert property (p_parity) else $error("parity flag wrong");

   property p_unused_zero;
      ack_o && $past(idx) == alarm_mon_pkg::IDX_BUS_LIVE |-> dat_o[4:3] == 2'b00;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero");

   property p_trib_off;
      fmt != alarm_mon_pkg::FMT_AU3 |-> bus_live[2:1] == 2'b00 && ext_live[2:1] == 2'b00;
   endproperty
   a_trib_off: assert property (p_trib_off) else $error("trib two/three not gated");

   property p_lof_cause;
      $rose(lof[0]) |-> $past(drop_rise && dh4 && bad_mf[0] && exp_h4 == 2'h3);
   endproperty
   a_lof_cause: assert property (p_lof_cause) else $error("multiframe loss without cause");

   property p_sticky;
      bus_lat[7] && !(wr && idx == alarm_mon_pkg::IDX_BUS_LAT) |=> bus_lat[7];
   endproperty
   a_sticky: assert property (p_sticky) else $error("latched bit lost");
endmodule // drop_add_bus_alarm_monitor
`default_nettype wire

// *** tb/drop_bus_src.sv ***
// Upstream drop bus source: clock, bytes, parity and overhead marks.
// Assumes the bench changes its controls only while frames are running.
`timescale 1ns/1ns
`default_nettype none
module drop_bus_src (
   input wire logic run_i,
   input wire logic bad_par_i,
   input wire logic [1:0] ais_i,
   input wire logic bad_h4_i,
   output logic clk_o,
   output logic [7:0] data_o,
   output logic parity_o,
   output logic h1_o,
   output logic h2_o,
   output logic e1_o,
   output logic h4_o,
   output logic [1:0] trib_o
);
   logic [3:0] slot;
   initial begin
      clk_o = 1'h0;
      slot = 4'h0;
   end
   // Clock stands still while stopped; bytes change on the falling edge
   always begin
      if (run_i === 1'h1) begin
         #200 clk_o = 1'h1;
         #200 clk_o = 1'h0;
         slot = slot + 4'h1;
      end else begin
         #50;
      end
   end
   assign h1_o = slot[1:0] == 2'h0;
   assign h2_o = slot[1:0] == 2'h1;
   assign e1_o = slot[1:0] == 2'h2;
   assign h4_o = slot[1:0] == 2'h3;
   assign trib_o = 2'h0;
   assign data_o = h4_o ? {6'h00, slot[3:2] ^ {2{bad_h4_i}}} :
      (((h1_o | h2_o) & ais_i[0]) | (e1_o & ais_i[1])) ? 8'hFF : 8'h00;
   // Even parity unless told to break it
   assign parity_o = (^data_o) ^ bad_par_i;
endmodule // drop_bus_src
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the drop/add bus alarm monitor.
// Assumes the drop bus source model and the design package are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
   localparam logic [5:0] BT = alarm_mon_pkg::IDX_BUS_LAT;
   localparam logic [5:0] BL = alarm_mon_pkg::IDX_BUS_LIVE;
   localparam logic [5:0] EL = alarm_mon_pkg::IDX_EXT_LIVE;
   localparam logic [5:0] CT = alarm_mon_pkg::IDX_CTRL;
   logic clk_i, rst_i, we, cyc, stb, ack_o, irq_o, dclk, aclk, xclk, par, h1, h2, e1, h4;
   logic [7:0] adr, ddat, ado, q;
   logic [31:0] dat, dat_o;
   logic [1:0] trib, ais;
   logic apo, aio, aoe, run, arun, xrun, bpar, bh4;
   int num_errors, checks, cycles;
   drop_add_bus_alarm_monitor dut_u (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
      .dat_i(dat), .sel_i(4'hF), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(dat_o),
      .ack_o(ack_o), .irq_o(irq_o), .drop_clk_i(dclk), .add_clk_i(aclk),
      .desync_ref_clock_i(xclk), .drop_data_i(ddat), .drop_parity_i(par),
      .drop_h1_i(h1), .drop_h2_i(h2), .drop_e1_i(e1), .drop_h4_i(h4), .drop_trib_i(trib),
      .add_data_i(8'h5A), .add_parity_i(1'h1), .add_indicator_i(1'h1), .add_data_o(ado),
      .add_parity_o(apo), .add_indicator_o(aio), .add_oe_o(aoe));
   drop_bus_src src_u (.run_i(run), .bad_par_i(bpar), .ais_i(ais), .bad_h4_i(bh4),
      .clk_o(dclk), .data_o(ddat), .parity_o(par), .h1_o(h1), .h2_o(h2), .e1_o(e1),
      .h4_o(h4), .trib_o(trib));
   initial begin
      clk_i = 1'h0;
      forever #25 clk_i = ~clk_i;
   end
   // Add clock toggles every 200 ns, on clk_i falling edges; reference clock toggles every 210 ns
   initial aclk = 1'h0;
   always #200 if (arun) aclk = ~aclk;
   initial xclk = 1'h0;
   always #210 if (xrun) xclk = ~xclk;
   task print_verdict;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic tk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wb(input logic [5:0] i, input logic w, input logic [7:0] d,
         output logic [7:0] r);
      int n;
      @(posedge clk_i);
      adr <= {i, 2'h0};
      dat <= {24'h000000, d};
      we <= w;
      cyc <= 1'h1;
      stb <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'h1 && n < 50);
      r = dat_o[7:0];
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      `CHK("ack", 1'h1, ack_o)
   endtask
   task automatic rd(input logic [5:0] i);
      wb(i, 1'h0, 8'h00, q);
   endtask
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      logic [7:0] x;
      wb(i, 1'h1, d, x);
   endtask
   task automatic t_reset;
      rd(EL);
      `CHK("ext live", 8'h07, q)
      rd(alarm_mon_pkg::IDX_B_LAT);
      `CHK("b latched", 8'h00, q)
      rd(6'h3F);
      `CHK("unmapped", 8'h00, q)
   endtask
   task automatic t_parity;
      tk(40);
      rd(BL);
      `CHK("bus clean", 8'h00, q)
      bpar <= 1'h1;
      tk(20);
      rd(BL);
      `CHK("bus par", 8'h20, q)
      `CHK("add data", 8'h5A, ado)
      `CHK("add oe", 1'h1, aoe)
      `CHK("add ind", 1'h1, aio)
      `CHK("add par", 1'h1, apo)
      bpar <= 1'h0;
      tk(20);
      rd(BL);
      `CHK("bus par off", 8'h00, q)
      wr(CT, 8'h08);
      tk(20);
      rd(BL);
      `CHK("odd par err", 8'h20, q)
      bpar <= 1'h1;
      tk(20);
      rd(BL);
      `CHK("odd par ok", 8'h00, q)
      bpar <= 1'h0;
      wr(CT, 8'h00);
      tk(20);
   endtask
   task automatic t_ais;
      // Frame is 32 cycles; margin for H1 then H2 plus sync
      ais <= 2'h1;
      tk(60);
      rd(BL);
      `CHK("ais h1h2", 8'h01, q)
      wr(CT, 8'h02);
      tk(60);
      rd(BL);
      `CHK("ais e1 idle", 8'h00, q)
      ais <= 2'h3;
      tk(60);
      rd(BL);
      `CHK("ais e1", 8'h01, q)
      ais <= 2'h0;
      wr(CT, 8'h00);
      tk(60);
   endtask
   task automatic t_drop_loss;
      wr(alarm_mon_pkg::IDX_IRQ_EN, 8'h03);
      wr(alarm_mon_pkg::IDX_IRQ_CLR, 8'h03);
      wr(BT, 8'hFF);
      tk(3);
      `CHK("irq idle", 1'h0, irq_o)
      run <= 1'h0;
      tk(6);
      `CHK("oe early", 1'h1, aoe)
      tk(34);
      rd(BL);
      `CHK("drop loss", 8'h80, q)
      `CHK("oe loss", 1'h0, aoe)
      `CHK("ind loss", 1'h0, aio)
      `CHK("irq", 1'h1, irq_o)
      run <= 1'h1;
      tk(20);
      rd(BL);
      `CHK("drop back", 8'h00, q)
      `CHK("oe back", 1'h1, aoe)
      rd(BT);
      `CHK("latched", 8'h80, q)
      wr(BT, 8'h80);
      rd(BT);
      `CHK("latched clr", 8'h00, q)
   endtask
   task automatic t_add_loss;
      wr(CT, 8'h01);
      arun <= 1'h0;
      tk(40);
      rd(BL);
      `CHK("add loss", 8'h40, q)
      `CHK("oe add", 1'h0, aoe)
      `CHK("ind add", 1'h0, aio)
      arun <= 1'h1;
      tk(20);
      rd(BL);
      `CHK("add back", 8'h00, q)
      wr(CT, 8'h00);
   endtask
   task automatic t_ext_loss;
      xrun <= 1'h0;
      tk(40);
      rd(EL);
      `CHK("ext loss", 8'h80, q & 8'hF8)
      xrun <= 1'h1;
      tk(20);
      rd(EL);
      `CHK("ext back", 8'h00, q & 8'hF8)
   endtask
   task automatic t_multiframe;
      tk(700);
      rd(EL);
      `CHK("mf lock", 8'h06, q)
      bh4 <= 1'h1;
      tk(400);
      rd(EL);
      `CHK("mf loss", 8'h07, q)
      bh4 <= 1'h0;
      tk(700);
      rd(EL);
      `CHK("mf relock", 8'h06, q)
      wr(CT, 8'h10);
      tk(4);
      rd(EL);
      `CHK("mf fmt", 8'h00, q)
      wr(CT, 8'h04);
      bh4 <= 1'h1;
      tk(400);
      rd(EL);
      `CHK("mf frozen", 8'h06, q)
      bh4 <= 1'h0;
   endtask
   initial begin
      {num_errors, checks, cycles} = '0;
      {we, cyc, stb, bpar, bh4} = '0;
      {adr, dat, ais} = '0;
      {run, arun, xrun} = 3'h7;
      rst_i = 1'h1;
      tk(4);
      rst_i <= 1'h0;
      t_reset();
      t_parity();
      t_ais();
      t_drop_loss();
      t_add_loss();
      t_ext_loss();
      t_multiframe();
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
